// ==== bench/ccs_props.sv ====
// Checker for the bus handshakes and the interrupt line of the capture block
module ccs_props (
  // Clock and reset
  input logic        CLK,
  input logic        RESET,
  // Interrupt
  input logic        IRQ,
  // Write channels
  input logic        S_AXI_AWVALID,
  input logic        S_AXI_AWREADY,
  input logic        S_AXI_WVALID,
  input logic        S_AXI_WREADY,
  input logic        S_AXI_BVALID,
  input logic        S_AXI_BREADY,
  // Read channels
  input logic        S_AXI_ARVALID,
  input logic        S_AXI_ARREADY,
  input logic [31:0] S_AXI_RDATA,
  input logic [1:0]  S_AXI_RRESP,
  input logic        S_AXI_RVALID,
  input logic        S_AXI_RREADY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  // Handshake steps of a transfer
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence

  // Both halves held at the taking edge, register and response one edge later
  property p_wr_answer;
    s_wr_taken |-> ##2 S_AXI_BVALID;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  property p_rd_answer;
    s_rd_taken |=> S_AXI_RVALID;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_b_done;
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response repeated");
  property p_r_done;
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read response repeated");
  // A pending answer blocks new requests, so only one of each is in flight
  property p_ar_block;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_aw_block;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
  property p_err_zero;
    S_AXI_RVALID && S_AXI_RRESP != 2'h0 |-> S_AXI_RDATA == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  // The interrupt only drops after software wrote status or mask
  property p_irq_fall;
    $fell(IRQ) |-> $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt lost");
  property p_rst_quiet;
    @(posedge CLK) disable iff (1'b0) RESET |=> !IRQ && !S_AXI_BVALID && !S_AXI_RVALID;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
endmodule // ccs_props

bind ccs_top ccs_props u_ccs_props (.CLK(CLK), .RESET(RESET), .IRQ(IRQ),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// ==== bench/ccs_src_model.sv ====
// Partner model: capture source pins and prescaler taps seen by the block
module ccs_src_model (
  // Counter clock
  input  logic       clk,
  // Levels: line two, line three, 16K tap, 1K tap
  output logic [3:0] src
);
  timeunit 1ns;
  timeprecision 100ps;
  initial src = 4'h0;
  // Holds a level for n clocks; n below 2 breaks the minimum phase width
  task automatic hold(input int i, input logic v, input int n);
    src[i] <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule // ccs_src_model

// ==== bench/testbench.sv ====
// Self-checking testbench for the counter capture block
`include "ccs_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  src;
  logic        irq, awv = 1'b0, awr, wv = 1'b0, wrd, bv, arv = 1'b0, arr, rv;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  rows [4] = '{4'h0, 4'h6, 4'h9, 4'hF}; // Edge code, rise hit, fall hit
  int          n_mismatch = 0;
  int          checks_done = 0;

  always #12.5 clk = ~clk;

  ccs_src_model u_ccs_src_model (.clk(clk), .src(src));
  ccs_top u_ccs_top (.CLK(clk), .RESET(rst), .PORT_A_LINE_TWO(src[0]),
    .PORT_A_LINE_THREE(src[1]), .TAP_16K(src[2]), .TAP_1K(src[3]), .IRQ(irq),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1));

  task complete_run;
    $display("mismatches %0d of %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task hang;
    n_mismatch++;
    complete_run;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // Bus write: address and data released each when taken, response kept
  task wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    awa <= a;
    wd  <= v;
    awv <= 1'b1;
    wv  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    r = bresp;
    if (n == 40) hang();
  endtask
  task rd(input logic [7:0] a);
    int n;
    ara <= a;
    arv <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    d = rdata;
    r = rresp;
    if (n == 40) hang();
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    hang();
  end

  initial begin
    int i, s, k;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 24; i += 4) rc(i[7:0], 32'h0);
    chk(irq, 32'h0);
    // Rows: every source with every edge code, rising then falling level
    wr(`CCS_ADDR_MASK, 32'h3);
    for (s = 0; s < 4; s++)
      for (k = 0; k < 4; k++) begin
        wr(`CCS_ADDR_CONFIG2, {28'h0, s[1:0], rows[k][3:2]});
        u_ccs_src_model.hold(s, 1'b1, 8);
        rc(`CCS_ADDR_STATUS, {30'h0, {2{rows[k][1]}}});
        chk(irq, {31'h0, rows[k][1]});
        wr(`CCS_ADDR_STATUS, 32'h3);
        u_ccs_src_model.hold(s, 1'b0, 8);
        rc(`CCS_ADDR_STATUS, {30'h0, {2{rows[k][0]}}});
        wr(`CCS_ADDR_STATUS, 32'h3);
      end
    // Unmapped address
    rd(8'h18);
    chk(r, 32'h2);
    chk(d, 32'h0);
    wr(8'h18, 32'hFF);
    chk(r, 32'h2);
    // Masking holds the line low; unmasking and clearing move it
    wr(`CCS_ADDR_MASK, 32'h0);
    wr(`CCS_ADDR_CONFIG2, 32'h1);
    u_ccs_src_model.hold(0, 1'b1, 3);
    u_ccs_src_model.hold(0, 1'b0, 8);
    rc(`CCS_ADDR_STATUS, 32'h3);
    chk(irq, 32'h0);
    wr(`CCS_ADDR_MASK, 32'h3);
    repeat (2) @(posedge clk);
    chk(irq, 32'h1);
    wr(`CCS_ADDR_STATUS, 32'h3);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0);
    // Shadow keeps the captured pair while the live count moves on
    wr(`CCS_ADDR_COUNT, 32'hA55A);
    u_ccs_src_model.hold(0, 1'b1, 8);
    u_ccs_src_model.hold(0, 1'b0, 4);
    chk(irq, 32'h1);
    rc(`CCS_ADDR_COUNT, 32'hA55A);
    wr(`CCS_ADDR_COUNT, 32'h1234);
    rc(`CCS_ADDR_COUNT, 32'hA55A);
    rc(`CCS_ADDR_LIVE, 32'h1234);
    wr(`CCS_ADDR_CONFIG2, 32'h0);
    rc(`CCS_ADDR_COUNT, 32'h1234);
    // One-cycle pulse must be ignored
    wr(`CCS_ADDR_CONFIG2, 32'h5);
    wr(`CCS_ADDR_STATUS, 32'h3);
    u_ccs_src_model.hold(1, 1'b1, 1);
    u_ccs_src_model.hold(1, 1'b0, 8);
    rc(`CCS_ADDR_STATUS, 32'h0);
    // Cascaded down from zero reaches the top of 16 bits
    wr(`CCS_ADDR_COUNT, 32'h0);
    wr(`CCS_ADDR_CTRL, 32'h15);
    repeat (20) @(posedge clk);
    wr(`CCS_ADDR_CTRL, 32'h0);
    rd(`CCS_ADDR_LIVE);
    chk(d[15:8], 32'hFF);
    // Separate A counts up over 0xFF and leaves B alone
    wr(`CCS_ADDR_COUNT, 32'hFF);
    wr(`CCS_ADDR_CTRL, 32'h09);
    repeat (20) @(posedge clk);
    wr(`CCS_ADDR_CTRL, 32'h0);
    rd(`CCS_ADDR_LIVE);
    chk(d[15:7], 32'h0);
    // Separate A counts down under zero to 0xFF and never borrows from B
    wr(`CCS_ADDR_COUNT, 32'h0);
    wr(`CCS_ADDR_CTRL, 32'h01);
    repeat (20) @(posedge clk);
    wr(`CCS_ADDR_CTRL, 32'h0);
    rd(`CCS_ADDR_LIVE);
    chk(d[15:8], 32'h0);
    chk(d[7], 32'h1);
    // Mid-run reset with the interrupt up clears every register and the line
    u_ccs_src_model.hold(1, 1'b1, 4);
    u_ccs_src_model.hold(1, 1'b0, 4);
    chk(irq, 32'h1);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(irq, 32'h0);
    for (i = 0; i < 24; i += 4) rc(i[7:0], 32'h0);
    complete_run;
  end
endmodule // testbench

// ==== core/ccs_edge.v ====
// Synchroniser, pulse-width filter and edge detector for one capture source
module ccs_edge (
  // Clock and reset
  input  wire CLK,
  input  wire RESET,
  // Raw source level
  input  wire SAMPLE_IN,
  // One-cycle edge pulses
  output reg  RISE,
  output reg  FALL
);

  reg sync1_q;
  reg sync2_q;
  reg hist_q;
  reg level_q;
  wire settle_d;

  // A new level is accepted only once it has been seen on two clocks running,
  // so a phase no longer than one clock period never makes an edge
  assign settle_d = (sync2_q == hist_q) && (hist_q != level_q); // [R14]

  // Two-stage synchroniser; first stage feeds the second stage only
  always @(posedge CLK) begin
    if (RESET) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      hist_q  <= 1'b0;
      level_q <= 1'b0;
      RISE    <= 1'b0;
      FALL    <= 1'b0;
    end else begin
      sync1_q <= SAMPLE_IN; // [R17]
      sync2_q <= sync1_q;   // [R17]
      hist_q  <= sync2_q;
      if (settle_d) begin
        level_q <= hist_q;
      end
      RISE <= settle_d & hist_q;
      FALL <= settle_d & ~hist_q;
    end
  end

endmodule // ccs_edge

// ==== core/ccs_regs.vh ====
// Register map, field positions and encodings for the counter capture block
`ifndef CCS_REGS_VH
`define CCS_REGS_VH

// Register byte offsets
`define CCS_ADDR_CTRL      8'h00
`define CCS_ADDR_CONFIG2   8'h04
`define CCS_ADDR_COUNT     8'h08
`define CCS_ADDR_LIVE      8'h0C
`define CCS_ADDR_STATUS    8'h10
`define CCS_ADDR_MASK      8'h14
`define CCS_ADDR_W         8

// Control register fields
`define CCS_CTRL_RUN_A     0
`define CCS_CTRL_RUN_B     1
`define CCS_CTRL_JOIN      2
`define CCS_CTRL_DIR_A     3
`define CCS_CTRL_DIR_B     4
`define CCS_CTRL_W         5
`define CCS_CTRL_RST       5'h00

// Second config register fields
`define CCS_EDGE_LSB       0
`define CCS_EDGE_MSB       1
`define CCS_SRC_LSB        2
`define CCS_SRC_MSB        3
`define CCS_CFG2_RST       4'h0

// Edge select encodings
`define CCS_EDGE_OFF       2'h0
`define CCS_EDGE_RISE      2'h1
`define CCS_EDGE_FALL      2'h2
`define CCS_EDGE_BOTH      2'h3

// Source select encodings
`define CCS_SRC_LINE_TWO   2'h0
`define CCS_SRC_LINE_THREE 2'h1
`define CCS_SRC_TAP_16K    2'h2
`define CCS_SRC_TAP_1K     2'h3
`define CCS_NUM_SRC        4

// Status and mask bits
`define CCS_IRQ_A          0
`define CCS_IRQ_B          1
`define CCS_IRQ_W          2
`define CCS_IRQ_RST        2'h0

// Counter constants
`define CCS_CNT_RST        8'h00
`define CCS_CNT_ONE        8'h01
`define CCS_CNT_MAX        8'hFF
`define CCS_WIDE_ONE       16'h0001

// Bus responses
`define CCS_RESP_OKAY      2'h0
`define CCS_RESP_SLVERR    2'h2

`endif

// ==== core/ccs_top.v ====
// Counters A and B with capture shadows, interrupts and AXI4-Lite registers
//
// Functional notes
// R1 - A 16-bit capture register holds a readable snapshot of running counters A and B.
// R2 - With capture enabled, count reads return the shadow registers, not live counts.
// R3 - On the capture condition shadows update first, then the capture interrupt rises.
// R4 - Counters A and B share one capture condition.
// R5 - Counters wrap: overflow to zero, underflow to 0xFF or 0xFFFF when cascaded.
// R6 - Capture keeps working whatever else the counters are used for.
// R7 - Edge select: 00 off, 01 rising, 10 falling, 11 both edges.
// R8 - Source select: 11 1K tap, 10 16K tap, 01 line three, 00 line two.
// R9 - Every source allows any edge; both edges on taps doubles the capture rate.
// R10 - Software changes edge and source select only while counters are stopped.
// R11 - Capture interrupt follows the capture condition by one or two counter clocks.
// R12 - Uncascaded counters on different clocks may raise their interrupts apart.
// R13 - Software reads a shadow only after that counter's own capture interrupt.
// R14 - An edge counts only if low and high phases exceed one clock period.
// R15 - Cascade setting joins A and B into one 16-bit counter steered by A.
// R16 - Direction bit set counts up, cleared counts down.
// R17 - Capture inputs pass a two-stage synchroniser before edge detection.
// R18 - Both shadow halves load together in one clock cycle.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`include "ccs_regs.vh"

module ccs_top (
  // Clock and reset
  input  wire        CLK,
  input  wire        RESET,
  // Capture sources
  input  wire        PORT_A_LINE_TWO,
  input  wire        PORT_A_LINE_THREE,
  input  wire        TAP_16K,
  input  wire        TAP_1K,
  // Interrupt
  output reg         IRQ,
  // AXI4-Lite write address
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  // AXI4-Lite write response
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  // AXI4-Lite read data
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY
);

  // Configuration and state
  reg  [`CCS_CTRL_W-1:0] ctrl_q;
  reg  [3:0]             counter_config_second_q;
  reg  [7:0]             cnt_a_q;
  reg  [7:0]             cnt_b_q;
  reg  [7:0]             cnt_a_d;
  reg  [7:0]             cnt_b_d;
  reg  [15:0]            shadow_q;
  reg                    shadow_new_q;
  reg  [`CCS_IRQ_W-1:0]  status_q;
  reg  [`CCS_IRQ_W-1:0]  mask_q;
  // Bus holding registers
  reg                    aw_have_q;
  reg  [7:0]             aw_addr_q;
  reg                    w_have_q;
  reg  [31:0]            w_data_q;
  reg  [3:0]             w_strb_q;
  // Decoded fields and events
  wire [1:0]             capture_edge_select;
  wire [1:0]             capture_source_select;
  wire                   join_first_counter_pair;
  wire                   dir_a;
  wire                   dir_b;
  wire                   run_a;
  wire                   run_b;
  wire [`CCS_NUM_SRC-1:0] src_raw;
  wire [`CCS_NUM_SRC-1:0] src_rise;
  wire [`CCS_NUM_SRC-1:0] src_fall;
  reg                    cap_hit;
  wire                   wr_go;
  wire                   wr_count;
  wire                   ar_take;
  wire [15:0]            wide_cnt;
  wire [15:0]            wide_next;
  wire [1:0]             counter_event;
  reg  [31:0]            rd_data;
  reg                    rd_ok;
  integer                i;

  assign capture_edge_select     = counter_config_second_q[`CCS_EDGE_MSB:`CCS_EDGE_LSB];
  assign capture_source_select   = counter_config_second_q[`CCS_SRC_MSB:`CCS_SRC_LSB];
  assign join_first_counter_pair = ctrl_q[`CCS_CTRL_JOIN];
  assign dir_a                   = ctrl_q[`CCS_CTRL_DIR_A];
  assign dir_b                   = ctrl_q[`CCS_CTRL_DIR_B];
  assign run_a                   = ctrl_q[`CCS_CTRL_RUN_A];
  assign run_b                   = ctrl_q[`CCS_CTRL_RUN_B];

  // Source index follows the select encoding so the mux is a plain index
  assign src_raw[`CCS_SRC_LINE_TWO]   = PORT_A_LINE_TWO;
  assign src_raw[`CCS_SRC_LINE_THREE] = PORT_A_LINE_THREE;
  assign src_raw[`CCS_SRC_TAP_16K]    = TAP_16K;
  assign src_raw[`CCS_SRC_TAP_1K]     = TAP_1K;

  // One synchroniser and filter per source; taps go through it too so every
  // source sees the same latency
  genvar g;
  generate
    for (g = 0; g < `CCS_NUM_SRC; g = g + 1) begin : g_src
      ccs_edge u_edge (
        .CLK       (CLK),
        .RESET     (RESET),
        .SAMPLE_IN (src_raw[g]),
        .RISE      (src_rise[g]),
        .FALL      (src_fall[g])
      ); // [R17] [R14]
    end
  endgenerate

  // Capture condition from the selected source and edge; one event for both counters
  always @* begin
    case (capture_edge_select)
      `CCS_EDGE_OFF:  cap_hit = 1'b0;                                // [R7]
      `CCS_EDGE_RISE: cap_hit = src_rise[capture_source_select];     // [R7] [R8]
      `CCS_EDGE_FALL: cap_hit = src_fall[capture_source_select];     // [R7] [R8]
      `CCS_EDGE_BOTH: cap_hit = src_rise[capture_source_select]
                                | src_fall[capture_source_select];   // [R9]
      default:        cap_hit = 1'b0;
    endcase
  end

  // Counter next values; cascaded pair is steered by A's run and direction bits
  assign wide_cnt  = {cnt_b_q, cnt_a_q};
  assign wide_next = dir_a ? (wide_cnt + `CCS_WIDE_ONE)
                           : (wide_cnt - `CCS_WIDE_ONE); // [R15] [R16] [R5]

  always @* begin
    cnt_a_d = cnt_a_q;
    cnt_b_d = cnt_b_q;
    if (join_first_counter_pair) begin
      if (run_a) begin
        cnt_a_d = wide_next[7:0];  // [R15]
        cnt_b_d = wide_next[15:8]; // [R5]
      end
    end else begin
      if (run_a) begin
        cnt_a_d = dir_a ? cnt_a_q + `CCS_CNT_ONE : cnt_a_q - `CCS_CNT_ONE; // [R16] [R5]
      end
      if (run_b) begin
        cnt_b_d = dir_b ? cnt_b_q + `CCS_CNT_ONE : cnt_b_q - `CCS_CNT_ONE; // [R16] [R5]
      end
    end
  end

  // Bus handshakes: address and data are taken in either order, one write at a time
  assign S_AXI_AWREADY = ~aw_have_q & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = ~w_have_q & ~S_AXI_BVALID;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  assign wr_go         = aw_have_q & w_have_q & ~S_AXI_BVALID;
  assign ar_take       = S_AXI_ARVALID & ~S_AXI_RVALID;
  assign wr_count      = wr_go && (aw_addr_q == `CCS_ADDR_COUNT);

  // Both counters share the capture event, so uncascaded halves report together
  assign counter_event = {`CCS_IRQ_W{shadow_new_q}}; // [R4] [R12]

  // Counters and capture shadow; a software load overrides counting
  always @(posedge CLK) begin
    if (RESET) begin
      cnt_a_q      <= `CCS_CNT_RST;
      cnt_b_q      <= `CCS_CNT_RST;
      shadow_q     <= {`CCS_CNT_RST, `CCS_CNT_RST};
      shadow_new_q <= 1'b0;
    end else begin
      if (wr_count && w_strb_q[0]) begin
        cnt_a_q <= w_data_q[7:0];
      end else begin
        cnt_a_q <= cnt_a_d;
      end
      if (wr_count && w_strb_q[1]) begin
        cnt_b_q <= w_data_q[15:8];
      end else begin
        cnt_b_q <= cnt_b_d;
      end
      // Capture runs regardless of run bits or any other use of the counters
      if (cap_hit) begin
        shadow_q <= wide_cnt; // [R1] [R4] [R18] [R6]
      end
      shadow_new_q <= cap_hit; // [R3]
    end
  end

  // Sticky status: a capture in the same cycle as a clear wins
  always @(posedge CLK) begin
    if (RESET) begin
      status_q <= `CCS_IRQ_RST;
      IRQ      <= 1'b0;
    end else begin
      for (i = 0; i < `CCS_IRQ_W; i = i + 1) begin
        if (counter_event[i]) begin
          status_q[i] <= 1'b1; // [R3] [R11]
        end else if (wr_go && aw_addr_q == `CCS_ADDR_STATUS && w_strb_q[0]
                     && w_data_q[i]) begin
          status_q[i] <= 1'b0;
        end
      end
      IRQ <= |(status_q & mask_q);
    end
  end

  // Write path and configuration registers
  always @(posedge CLK) begin
    if (RESET) begin
      aw_have_q               <= 1'b0;
      aw_addr_q               <= 8'h00;
      w_have_q                <= 1'b0;
      w_data_q                <= 32'h00000000;
      w_strb_q                <= 4'h0;
      S_AXI_BVALID            <= 1'b0;
      S_AXI_BRESP             <= `CCS_RESP_OKAY;
      ctrl_q                  <= `CCS_CTRL_RST;
      counter_config_second_q <= `CCS_CFG2_RST;
      mask_q                  <= `CCS_IRQ_RST;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= `CCS_RESP_OKAY;
        case (aw_addr_q)
          `CCS_ADDR_CTRL: begin
            if (w_strb_q[0]) begin
              ctrl_q <= w_data_q[`CCS_CTRL_W-1:0];
            end
          end
          // Edge and source fields should only change with counters stopped
          `CCS_ADDR_CONFIG2: begin
            if (w_strb_q[0]) begin
              counter_config_second_q <= w_data_q[`CCS_SRC_MSB:0]; // [R10]
            end
          end
          `CCS_ADDR_MASK: begin
            if (w_strb_q[0]) begin
              mask_q <= w_data_q[`CCS_IRQ_W-1:0];
            end
          end
          `CCS_ADDR_COUNT, `CCS_ADDR_STATUS: begin
            S_AXI_BRESP <= `CCS_RESP_OKAY;
          end
          default: begin
            S_AXI_BRESP <= `CCS_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Read decode; counts show the shadow while capture is enabled
  always @* begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    case (S_AXI_ARADDR)
      `CCS_ADDR_CTRL:    rd_data[`CCS_CTRL_W-1:0] = ctrl_q;
      `CCS_ADDR_CONFIG2: rd_data[`CCS_SRC_MSB:0]  = counter_config_second_q;
      `CCS_ADDR_COUNT:   rd_data[15:0] = (capture_edge_select != `CCS_EDGE_OFF)
                                         ? shadow_q : wide_cnt; // [R2] [R13]
      `CCS_ADDR_LIVE:    rd_data[15:0] = wide_cnt;
      `CCS_ADDR_STATUS:  rd_data[`CCS_IRQ_W-1:0] = status_q;
      `CCS_ADDR_MASK:    rd_data[`CCS_IRQ_W-1:0] = mask_q;
      default:           rd_ok = 1'b0;
    endcase
  end

  // Read channel: data registered at the same edge that takes the address
  always @(posedge CLK) begin
    if (RESET) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h00000000;
      S_AXI_RRESP  <= `CCS_RESP_OKAY;
    end else begin
      if (ar_take) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_data;
        S_AXI_RRESP  <= rd_ok ? `CCS_RESP_OKAY : `CCS_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule // ccs_top
